// File: logic/tdp_regs.svh
// Constants of the transceiver debug port
`ifndef TDP_REGS_SVH
`define TDP_REGS_SVH

`define TDP_CFG_ADDR_W      9
`define TDP_CFG_DATA_W      16
`define TDP_LOOP_W          3
`define TDP_EMPH_W          5
`define TDP_SWING_W         4
`define TDP_ELASTIC_W       3
`define TDP_LOOP_NONE       3'h0
`define TDP_LOOP_NEAR_PCS   3'h1
`define TDP_LOOP_NEAR_PMA   3'h2
`define TDP_LOOP_FAR_PMA    3'h4
`define TDP_LOOP_FAR_PCS    3'h6

// Wishbone register byte offsets of the user-side controller
`define TDP_REG_CTRL        4'h0
`define TDP_REG_CFG_CMD     4'h4
`define TDP_REG_CFG_RESULT  4'h8
`define TDP_REG_STATUS      4'hc

// Control register fields
`define TDP_CTRL_LOOP_LSB   0
`define TDP_CTRL_TXINV_BIT  3
`define TDP_CTRL_RXINV_BIT  4
`define TDP_CTRL_EYERST_BIT 5
`define TDP_CTRL_EYETRG_BIT 6
`define TDP_CTRL_ELRST_BIT  7
`define TDP_CTRL_SWING_LSB  8
`define TDP_CTRL_PRE_LSB    16
`define TDP_CTRL_POST_LSB   24
`define TDP_CTRL_RESET      32'h0000_0000

// Command register fields: data [15:0], address [24:16], write bit 25
`define TDP_CMD_ADDR_LSB    16
`define TDP_CMD_WRITE_BIT   25

// Status register fields
`define TDP_ST_BUSY_BIT     0
`define TDP_ST_DONE_BIT     1
`define TDP_ST_PLL_BIT      2
`define TDP_ST_EYEERR_BIT   3
`define TDP_ST_BYTELK_BIT   4
`define TDP_ST_MOVED_BIT    5
`define TDP_ST_ELASTIC_LSB  8

`endif

// File: logic/tdp_pkg.sv
// Types shared by both ends of the transceiver debug port
package tdp_pkg;
	`include "tdp_regs.svh"

	typedef logic [`TDP_LOOP_W-1:0] tdp_loop_type;

	typedef enum logic [2:0] {
		TDP_LOOPBACK_OFF = `TDP_LOOP_NONE,
		TDP_LOOPBACK_NPCS = `TDP_LOOP_NEAR_PCS,
		TDP_LOOPBACK_NPMA = `TDP_LOOP_NEAR_PMA,
		TDP_LOOPBACK_FPMA = `TDP_LOOP_FAR_PMA,
		TDP_LOOPBACK_FPCS = `TDP_LOOP_FAR_PCS
	} tdp_loop_mode_type;

	typedef enum logic [1:0] {
		TDP_CFG_IDLE,
		TDP_CFG_WAIT,
		TDP_CFG_DONE
	} tdp_cfg_state_type;
endpackage

// File: logic/tdp_if.sv
// Debug link between the core end and the user debug end
`timescale 1ns/1ns
`include "tdp_regs.svh"
interface tdp_if #(
	parameter int LANES = 1
);
	logic [`TDP_CFG_ADDR_W-1:0]   cfg_port_address;
	logic [`TDP_CFG_DATA_W-1:0]   cfg_port_write_data;
	logic                         cfg_port_access_enable;
	logic                         cfg_port_write_enable;
	logic [`TDP_CFG_DATA_W-1:0]   cfg_port_read_data;
	logic                         cfg_port_ready;
	logic [`TDP_LOOP_W-1:0]       loopback_select;
	logic [`TDP_EMPH_W-1:0]       tx_post_emphasis;
	logic [`TDP_EMPH_W-1:0]       tx_pre_emphasis;
	logic [`TDP_SWING_W-1:0]      tx_swing_setting;
	logic                         tx_invert;
	logic                         rx_invert;
	logic [32*LANES-1:0]          tx_raw_word_copy;
	logic [4*LANES-1:0]           tx_kchar_flags_copy;
	logic [32*LANES-1:0]          rx_raw_word_copy;
	logic [4*LANES-1:0]           rx_kchar_flags_copy;
	logic [4*LANES-1:0]           rx_running_sign_error_copy;
	logic [4*LANES-1:0]           rx_bad_code_copy;
	logic                         lane_pll_locked;
	logic                         eye_margin_error;
	logic                         eye_margin_reset;
	logic                         eye_margin_trigger;
	logic                         rx_elastic_reset;
	logic [`TDP_ELASTIC_W-1:0]    rx_elastic_state;
	logic                         rx_byte_locked;
	logic                         rx_byte_lock_moved;

	modport core (
		input  cfg_port_address, cfg_port_write_data, cfg_port_access_enable,
		input  cfg_port_write_enable, loopback_select, tx_post_emphasis,
		input  tx_pre_emphasis, tx_swing_setting, tx_invert, rx_invert,
		input  eye_margin_reset, eye_margin_trigger, rx_elastic_reset,
		output cfg_port_read_data, cfg_port_ready, tx_raw_word_copy,
		output tx_kchar_flags_copy, rx_raw_word_copy, rx_kchar_flags_copy,
		output rx_running_sign_error_copy, rx_bad_code_copy, lane_pll_locked,
		output eye_margin_error, rx_elastic_state, rx_byte_locked, rx_byte_lock_moved
	);

	modport user (
		output cfg_port_address, cfg_port_write_data, cfg_port_access_enable,
		output cfg_port_write_enable, loopback_select, tx_post_emphasis,
		output tx_pre_emphasis, tx_swing_setting, tx_invert, rx_invert,
		output eye_margin_reset, eye_margin_trigger, rx_elastic_reset,
		input  cfg_port_read_data, cfg_port_ready, tx_raw_word_copy,
		input  tx_kchar_flags_copy, rx_raw_word_copy, rx_kchar_flags_copy,
		input  rx_running_sign_error_copy, rx_bad_code_copy, lane_pll_locked,
		input  eye_margin_error, rx_elastic_state, rx_byte_locked, rx_byte_lock_moved
	);
endinterface

// File: logic/tdp_core_end.sv
// Core end of the debug port: forwards controls to the transceiver, copies status back
`timescale 1ns/1ns
`include "tdp_regs.svh"
module tdp_core_end #(
	parameter int LANES = 1
) (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	tdp_if.core                             dbg,
	output logic [`TDP_CFG_ADDR_W-1:0]      gt_cfg_address_o,
	output logic [`TDP_CFG_DATA_W-1:0]      gt_cfg_write_data_o,
	output logic                            gt_cfg_enable_o,
	output logic                            gt_cfg_write_o,
	input  wire logic [`TDP_CFG_DATA_W-1:0] gt_cfg_read_data_i,
	input  wire logic                       gt_cfg_ready_i,
	output tdp_pkg::tdp_loop_type           gt_loopback_o,
	output logic [`TDP_EMPH_W-1:0]          gt_tx_post_emphasis_o,
	output logic [`TDP_EMPH_W-1:0]          gt_tx_pre_emphasis_o,
	output logic [`TDP_SWING_W-1:0]         gt_tx_swing_o,
	output logic                            gt_tx_invert_o,
	output logic                            gt_rx_invert_o,
	output logic                            gt_eye_reset_o,
	output logic                            gt_eye_trigger_o,
	output logic                            gt_elastic_reset_o,
	input  wire logic [32*LANES-1:0]        tx_word_i,
	input  wire logic [4*LANES-1:0]         tx_kchar_i,
	input  wire logic [32*LANES-1:0]        rx_word_i,
	input  wire logic [4*LANES-1:0]         rx_kchar_i,
	input  wire logic [4*LANES-1:0]         rx_sign_err_i,
	input  wire logic [4*LANES-1:0]         rx_bad_code_i,
	input  wire logic                       gt_pll_locked_i,
	input  wire logic                       gt_eye_error_i,
	input  wire logic [`TDP_ELASTIC_W-1:0]  gt_elastic_state_i,
	input  wire logic                       gt_byte_locked_i,
	input  wire logic                       gt_byte_moved_i
);
	import tdp_pkg::*;

	// Present only when built with shared logic and debug ports; pure pass-through
	// Config port request and answer
	assign gt_cfg_address_o      = dbg.cfg_port_address;
	assign gt_cfg_write_data_o   = dbg.cfg_port_write_data;
	assign gt_cfg_enable_o       = dbg.cfg_port_access_enable;
	assign gt_cfg_write_o        = dbg.cfg_port_write_enable;
	assign dbg.cfg_port_ready    = gt_cfg_ready_i;
	assign dbg.cfg_port_read_data = gt_cfg_read_data_i;
	// Transceiver controls
	assign gt_loopback_o         = dbg.loopback_select;
	assign gt_tx_post_emphasis_o = dbg.tx_post_emphasis;
	assign gt_tx_pre_emphasis_o  = dbg.tx_pre_emphasis;
	assign gt_tx_swing_o         = dbg.tx_swing_setting;
	assign gt_tx_invert_o        = dbg.tx_invert;
	assign gt_rx_invert_o        = dbg.rx_invert;
	assign gt_eye_reset_o        = dbg.eye_margin_reset;
	assign gt_eye_trigger_o      = dbg.eye_margin_trigger;
	assign gt_elastic_reset_o    = dbg.rx_elastic_reset;
	// Raw bus copies and status
	assign dbg.tx_raw_word_copy           = tx_word_i;
	assign dbg.tx_kchar_flags_copy        = tx_kchar_i;
	assign dbg.rx_raw_word_copy           = rx_word_i;
	assign dbg.rx_kchar_flags_copy        = rx_kchar_i;
	assign dbg.rx_running_sign_error_copy = rx_sign_err_i;
	assign dbg.rx_bad_code_copy           = rx_bad_code_i;
	assign dbg.lane_pll_locked            = gt_pll_locked_i;
	assign dbg.eye_margin_error           = gt_eye_error_i;
	assign dbg.rx_elastic_state           = gt_elastic_state_i;
	assign dbg.rx_byte_locked             = gt_byte_locked_i;
	assign dbg.rx_byte_lock_moved         = gt_byte_moved_i;
endmodule

// File: logic/tdp_cfg_access.sv
// Single-access sequencer for the transceiver configuration port
`timescale 1ns/1ns
`include "tdp_regs.svh"
module tdp_cfg_access (
	input  wire logic                       clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       start_i,
	input  wire logic                       write_i,
	input  wire logic [`TDP_CFG_ADDR_W-1:0] addr_i,
	input  wire logic [`TDP_CFG_DATA_W-1:0] wdata_i,
	output logic                            busy_o,
	output logic                            done_o,
	output logic [`TDP_CFG_DATA_W-1:0]      rdata_o,
	output logic [`TDP_CFG_ADDR_W-1:0]      cfg_addr_o,
	output logic [`TDP_CFG_DATA_W-1:0]      cfg_wdata_o,
	output logic                            cfg_en_o,
	output logic                            cfg_we_o,
	input  wire logic                       cfg_ready_i,
	input  wire logic [`TDP_CFG_DATA_W-1:0] cfg_rdata_i
);
	import tdp_pkg::*;

	tdp_cfg_state_type state_reg;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			state_reg <= TDP_CFG_IDLE;
		end else begin
			unique case (state_reg)
				TDP_CFG_IDLE: begin
					if (start_i) begin
						state_reg <= TDP_CFG_WAIT;
					end
				end
				TDP_CFG_WAIT: begin
					if (cfg_ready_i) begin
						state_reg <= TDP_CFG_DONE;
					end
				end
				TDP_CFG_DONE: begin
					if (start_i) begin
						state_reg <= TDP_CFG_WAIT;
					end
				end
				default: state_reg <= TDP_CFG_IDLE;
			endcase
		end
	end

	// Enable is a single-cycle strobe; held low otherwise
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_en_o <= 1'b0;
		end else begin
			cfg_en_o <= start_i && (state_reg != TDP_CFG_WAIT);
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			cfg_we_o    <= 1'b0;
			cfg_addr_o  <= '0;
			cfg_wdata_o <= '0;
		end else if (start_i && (state_reg != TDP_CFG_WAIT)) begin
			cfg_we_o    <= write_i;
			cfg_addr_o  <= addr_i;
			cfg_wdata_o <= wdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_o <= '0;
		end else if (state_reg == TDP_CFG_WAIT && cfg_ready_i && !cfg_we_o) begin
			rdata_o <= cfg_rdata_i;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
		end else begin
			busy_o <= (state_reg == TDP_CFG_WAIT) ? !cfg_ready_i : start_i;
			done_o <= (state_reg == TDP_CFG_WAIT) ? cfg_ready_i : (done_o && !start_i);
		end
	end
endmodule

// File: logic/tdp_user_end.sv
// User debug end: Wishbone registers driving the transceiver debug port
//
// Notes on behaviour
// - Port exists only with shared logic option.
// - User drives inputs per transceiver rules.
// - Config access: 9-bit address, 16-bit write data.
// - Access enable low idle, high launches access.
// - Write enable picks read or write.
// - Ready marks write done or data valid.
// - Read data is 16 bits, config clock.
// - Three-bit loopback select with five modes.
// - Transmit post, pre emphasis and swing.
// - Transmit invert flips transmitted polarity.
// - Receive invert flips received polarity.
// - Raw data and k-char bus copies.
// - Receive error flag copies per byte.
// - Lane PLL locked flag, active high.
// - Eye-margin reset is a high pulse.
// - Trigger level causes event; error flag out.
// - Elastic reset high then released.
// - Three-bit elastic buffer state output.
// - Byte locked and lock moved flags.
//
// Local design decisions: the register offsets and the Wishbone slave port.
`timescale 1ns/1ns
`include "tdp_regs.svh"
module tdp_user_end (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [3:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]      wb_dat_o,
	output logic             wb_ack_o,
	tdp_if.user              dbg
);
	import tdp_pkg::*;

	////////////////////////////////////////////////////////////////////////////
	// Bus decode

	logic        wr_stb;
	logic        rd_stb;
	logic        ctrl_write;
	logic        status_read;
	logic [31:0] ctrl_reg;
	logic [31:0] ctrl_next;
	logic        start_access;
	logic        cfg_busy;
	logic        cfg_done;
	logic [15:0] cfg_result;
	logic        eye_pulse_reg;
	logic        elastic_pulse_reg;
	logic        moved_seen_reg;
	logic [31:0] status_word;

	assign wr_stb = wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o;
	assign rd_stb = wb_cyc_i && wb_stb_i && !wb_we_i && !wb_ack_o;
	assign start_access = wr_stb && wb_adr_i == `TDP_REG_CFG_CMD && !cfg_busy;
	assign ctrl_write = wr_stb && wb_adr_i == `TDP_REG_CTRL;
	assign status_read = rd_stb && wb_adr_i == `TDP_REG_STATUS;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_ack_o <= 1'b0;
		end else begin
			wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Control register, byte lanes honoured

	always_comb begin
		ctrl_next = ctrl_reg;
		for (int b = 0; b < 4; b++) begin
			if (wb_sel_i[b]) begin
				ctrl_next[8*b +: 8] = wb_dat_i[8*b +: 8];
			end
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ctrl_reg <= `TDP_CTRL_RESET;
		end else if (ctrl_write) begin
			ctrl_reg <= ctrl_next;
		end
	end

	// Static controls driven from flip-flops
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbg.loopback_select <= `TDP_LOOP_NONE;
		end else begin
			dbg.loopback_select <= ctrl_reg[`TDP_CTRL_LOOP_LSB +: `TDP_LOOP_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbg.tx_post_emphasis <= '0;
			dbg.tx_pre_emphasis  <= '0;
			dbg.tx_swing_setting <= '0;
		end else begin
			dbg.tx_post_emphasis <= ctrl_reg[`TDP_CTRL_POST_LSB +: `TDP_EMPH_W];
			dbg.tx_pre_emphasis  <= ctrl_reg[`TDP_CTRL_PRE_LSB +: `TDP_EMPH_W];
			dbg.tx_swing_setting <= ctrl_reg[`TDP_CTRL_SWING_LSB +: `TDP_SWING_W];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbg.tx_invert <= 1'b0;
			dbg.rx_invert <= 1'b0;
		end else begin
			dbg.tx_invert <= ctrl_reg[`TDP_CTRL_TXINV_BIT];
			dbg.rx_invert <= ctrl_reg[`TDP_CTRL_RXINV_BIT];
		end
	end

	// Trigger is a level held as long as the control bit stays set
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dbg.eye_margin_trigger <= 1'b0;
		end else begin
			dbg.eye_margin_trigger <= ctrl_reg[`TDP_CTRL_EYETRG_BIT];
		end
	end

	// Reset requests: writing a one yields a single high pulse, then release
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			eye_pulse_reg <= 1'b0;
		end else begin
			eye_pulse_reg <= ctrl_write && ctrl_next[`TDP_CTRL_EYERST_BIT];
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			elastic_pulse_reg <= 1'b0;
		end else begin
			elastic_pulse_reg <= ctrl_write && ctrl_next[`TDP_CTRL_ELRST_BIT];
		end
	end

	assign dbg.eye_margin_reset = eye_pulse_reg;
	assign dbg.rx_elastic_reset = elastic_pulse_reg;

	////////////////////////////////////////////////////////////////////////////
	// Configuration port access

	tdp_cfg_access u_cfg (
		.clk_i       (clk_i),
		.rst_i       (rst_i),
		.start_i     (start_access),
		.write_i     (wb_dat_i[`TDP_CMD_WRITE_BIT]),
		.addr_i      (wb_dat_i[`TDP_CMD_ADDR_LSB +: `TDP_CFG_ADDR_W]),
		.wdata_i     (wb_dat_i[`TDP_CFG_DATA_W-1:0]),
		.busy_o      (cfg_busy),
		.done_o      (cfg_done),
		.rdata_o     (cfg_result),
		.cfg_addr_o  (dbg.cfg_port_address),
		.cfg_wdata_o (dbg.cfg_port_write_data),
		.cfg_en_o    (dbg.cfg_port_access_enable),
		.cfg_we_o    (dbg.cfg_port_write_enable),
		.cfg_ready_i (dbg.cfg_port_ready),
		.cfg_rdata_i (dbg.cfg_port_read_data)
	);

	////////////////////////////////////////////////////////////////////////////
	// Status and read data

	// Alignment change is sticky until status is read; a new change wins
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			moved_seen_reg <= 1'b0;
		end else if (dbg.rx_byte_lock_moved) begin
			moved_seen_reg <= 1'b1;
		end else if (status_read) begin
			moved_seen_reg <= 1'b0;
		end
	end

	always_comb begin
		status_word = '0;
		status_word[`TDP_ST_BUSY_BIT]   = cfg_busy;
		status_word[`TDP_ST_DONE_BIT]   = cfg_done;
		status_word[`TDP_ST_PLL_BIT]    = dbg.lane_pll_locked;
		status_word[`TDP_ST_EYEERR_BIT] = dbg.eye_margin_error;
		status_word[`TDP_ST_BYTELK_BIT] = dbg.rx_byte_locked;
		status_word[`TDP_ST_MOVED_BIT]  = moved_seen_reg;
		status_word[`TDP_ST_ELASTIC_LSB +: `TDP_ELASTIC_W] = dbg.rx_elastic_state;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			wb_dat_o <= '0;
		end else if (rd_stb) begin
			unique case (wb_adr_i)
				`TDP_REG_CTRL:       wb_dat_o <= ctrl_reg;
				`TDP_REG_CFG_CMD:    wb_dat_o <= '0;
				`TDP_REG_CFG_RESULT: wb_dat_o <= {16'h0000, cfg_result};
				`TDP_REG_STATUS:     wb_dat_o <= status_word;
				default:             wb_dat_o <= '0;
			endcase
		end
	end
endmodule

// File: sim/tdp_link_checker_assertions.sv
// Concurrent checks on the debug link between the user end and the core end
`timescale 1ns/1ns
module tdp_link_checker (
	input wire logic                  clk_i,
	input wire logic                  rst_i,
	input wire logic [8:0]            cfg_port_address,
	input wire logic [15:0]           cfg_port_write_data,
	input wire logic                  cfg_port_access_enable,
	input wire logic                  cfg_port_ready,
	input wire logic [15:0]           cfg_port_read_data,
	input wire logic [2:0]            loopback_select,
	input wire logic                  lane_pll_locked,
	input wire logic                  eye_margin_reset,
	input wire logic                  rx_elastic_reset,
	input wire logic                  gt_cfg_ready_i,
	input wire logic [15:0]           gt_cfg_read_data_i,
	input wire logic                  gt_pll_locked_i,
	input wire tdp_pkg::tdp_loop_type gt_loopback_o
);
	import tdp_pkg::*;

	default clocking @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	a_access_one_cycle: assert property (
		cfg_port_access_enable |=> !cfg_port_access_enable [*3])
		else $error("access enable longer than one cycle");
	a_request_held: assert property (
		!cfg_port_access_enable ##1 !cfg_port_access_enable
		|-> $stable(cfg_port_address) && $stable(cfg_port_write_data))
		else $error("access fields moved between accesses");
	a_ready_copy: assert property (
		cfg_port_ready == gt_cfg_ready_i)
		else $error("ready not passed through");
	a_rdata_copy: assert property (
		cfg_port_ready |-> cfg_port_read_data == gt_cfg_read_data_i)
		else $error("read data not passed through");
	a_loop_copy: assert property (
		gt_loopback_o == loopback_select)
		else $error("loopback select altered");
	a_pll_copy: assert property (
		lane_pll_locked == gt_pll_locked_i)
		else $error("pll lock flag altered");
	a_eye_pulse: assert property (
		$rose(eye_margin_reset) |=> !eye_margin_reset)
		else $error("eye margin reset not a pulse");
	a_elastic_pulse: assert property (
		rx_elastic_reset |=> $fell(rx_elastic_reset))
		else $error("elastic reset not released");

	cover property (cfg_port_access_enable ##[1:8] cfg_port_ready);
	cover property (eye_margin_reset ##1 !eye_margin_reset);
	cover property (rx_elastic_reset);
endmodule

// File: sim/testbench.sv
// Self-checking bench joining the user end and the core end of the debug port
`timescale 1ns/1ns
`include "tdp_regs.svh"
module testbench;
	import tdp_pkg::*;
	typedef struct packed {
		logic [31:0] ctrl;
		logic [19:0] outs;
	} tdp_row_type;
	logic         clk = 1'b0;
	logic         rst = 1'b1;
	logic         cyc = 1'b0, stb = 1'b0, we = 1'b0;
	logic [3:0]   adr = 4'h0, sel = 4'h0;
	logic [31:0]  dat = 32'h0, rdat, q;
	logic         ack;
	logic [8:0]   g_ad, lad = 9'h0;
	logic [15:0]  g_wd, g_rd, rdq = 16'h0;
	logic         g_en, g_we, g_ti, g_ri, g_er, g_et, g_el;
	logic         g_rdy = 1'b0;
	tdp_loop_type g_lp;
	logic [4:0]   g_po, g_pr;
	logic [3:0]   g_sw;
	logic [31:0]  tw = 32'h0, rw = 32'h0;
	logic [3:0]   tk = 4'h0, rk = 4'h0, se = 4'h0, bc = 4'h0;
	logic         pll = 1'b0, eer = 1'b0, blk = 1'b0, bmv = 1'b0;
	logic [2:0]   est = 3'h0;
	logic [1:0]   pend = 2'h0;
	logic [15:0]  mem [512];
	int           nacc = 0, ner = 0, nel = 0, cycles = 0, compares = 0, mismatches = 0;
	wire [19:0]   outs = {g_lp, g_sw, g_pr, g_po, g_et, g_ri, g_ti};
	tdp_row_type  rows [5] = '{
		'{32'h1f00_0f08, {3'h0, 4'hf, 5'h00, 5'h1f, 3'h1}},
		'{32'h001f_0011, {3'h1, 4'h0, 5'h1f, 5'h00, 3'h2}},
		'{32'h150a_0542, {3'h2, 4'h5, 5'h0a, 5'h15, 3'h4}},
		'{32'h0a15_0a5c, {3'h4, 4'ha, 5'h15, 5'h0a, 3'h7}},
		'{32'h0101_0106, {3'h6, 4'h1, 5'h01, 5'h01, 3'h0}}
	};

	tdp_if #(.LANES(1)) i_tdp_if ();
	tdp_user_end i_tdp_user_end (
		.clk_i(clk), .rst_i(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
		.wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
		.dbg(i_tdp_if)
	);
	tdp_core_end #(.LANES(1)) i_tdp_core_end (
		.clk_i(clk), .rst_i(rst), .dbg(i_tdp_if),
		.gt_cfg_address_o(g_ad), .gt_cfg_write_data_o(g_wd), .gt_cfg_enable_o(g_en),
		.gt_cfg_write_o(g_we), .gt_cfg_read_data_i(g_rd), .gt_cfg_ready_i(g_rdy),
		.gt_loopback_o(g_lp), .gt_tx_post_emphasis_o(g_po), .gt_tx_pre_emphasis_o(g_pr),
		.gt_tx_swing_o(g_sw), .gt_tx_invert_o(g_ti), .gt_rx_invert_o(g_ri),
		.gt_eye_reset_o(g_er), .gt_eye_trigger_o(g_et), .gt_elastic_reset_o(g_el),
		.tx_word_i(tw), .tx_kchar_i(tk), .rx_word_i(rw), .rx_kchar_i(rk),
		.rx_sign_err_i(se), .rx_bad_code_i(bc), .gt_pll_locked_i(pll),
		.gt_eye_error_i(eer), .gt_elastic_state_i(est), .gt_byte_locked_i(blk),
		.gt_byte_moved_i(bmv)
	);
	tdp_link_checker i_tdp_link_checker (
		.clk_i(clk), .rst_i(rst),
		.cfg_port_address(i_tdp_if.cfg_port_address),
		.cfg_port_write_data(i_tdp_if.cfg_port_write_data),
		.cfg_port_access_enable(i_tdp_if.cfg_port_access_enable),
		.cfg_port_ready(i_tdp_if.cfg_port_ready),
		.cfg_port_read_data(i_tdp_if.cfg_port_read_data),
		.loopback_select(i_tdp_if.loopback_select),
		.lane_pll_locked(i_tdp_if.lane_pll_locked),
		.eye_margin_reset(i_tdp_if.eye_margin_reset),
		.rx_elastic_reset(i_tdp_if.rx_elastic_reset),
		.gt_cfg_ready_i(g_rdy), .gt_cfg_read_data_i(g_rd), .gt_pll_locked_i(pll),
		.gt_loopback_o(g_lp)
	);

	always #20 clk = ~clk;

	// Transceiver stand-in: answers each access three cycles later, data garbled outside ready
	always @(posedge clk) begin
		g_rdy <= 1'b0;
		if (pend == 2'h1)
			g_rdy <= 1'b1;
		if (pend != 2'h0)
			pend <= pend - 2'h1;
		if (g_en === 1'b1) begin
			nacc++;
			lad <= g_ad;
			pend <= 2'h3;
			if (g_we)
				mem[g_ad] <= g_wd;
			else
				rdq <= mem[g_ad];
		end
	end
	assign g_rd = g_rdy ? rdq : ~rdq;

	always @(posedge clk) begin
		if (g_er === 1'b1)
			ner++;
		if (g_el === 1'b1)
			nel++;
		cycles++;
		if (cycles == 3000) begin
			mismatches++;
			test_done();
		end
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d,
		input logic [3:0] s, output logic [31:0] r);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= s;
		dat <= d;
		do @(posedge clk); while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk);
	endtask

	task automatic wr(input logic [3:0] a, input logic [31:0] d);
		wb(1'b1, a, d, 4'hf, q);
	endtask

	task automatic rdc(input logic [3:0] a, input logic [31:0] e);
		wb(1'b0, a, 32'h0, 4'hf, q);
		chk(q, e);
	endtask

	task automatic cfg_wait;
		q = 32'h0;
		while (q[`TDP_ST_DONE_BIT] !== 1'b1)
			wb(1'b0, `TDP_REG_STATUS, 32'h0, 4'hf, q);
	endtask

	task automatic test_done;
		$display("Comparisons %0d, mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	initial begin
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		chk({12'h0, outs}, 32'h0);
		rdc(`TDP_REG_CTRL, `TDP_CTRL_RESET);
		rdc(`TDP_REG_STATUS, 32'h0);
		foreach (rows[i]) begin
			wr(`TDP_REG_CTRL, rows[i].ctrl);
			rdc(`TDP_REG_CTRL, rows[i].ctrl);
			chk({12'h0, outs}, {12'h0, rows[i].outs});
		end
		wr(`TDP_REG_CFG_CMD, 32'h03ff_beef);
		// The stand-in answers late enough that this read sees busy set
		rdc(`TDP_REG_STATUS, 32'h0000_0001);
		cfg_wait();
		chk({7'h0, lad, mem[9'h1ff]}, {7'h0, 9'h1ff, 16'hbeef});
		rdc(`TDP_REG_CFG_CMD, 32'h0);
		wr(`TDP_REG_CFG_CMD, 32'h01ff_0000);
		cfg_wait();
		rdc(`TDP_REG_CFG_RESULT, 32'h0000_beef);
		// Second command lands while the first is outstanding and must be dropped
		wr(`TDP_REG_CFG_CMD, 32'h0201_5a5a);
		wr(`TDP_REG_CFG_CMD, 32'h0202_a5a5);
		cfg_wait();
		chk({7'h0, lad, 16'(nacc)}, {7'h0, 9'h001, 16'h3});
		pll <= 1'b1;
		eer <= 1'b1;
		blk <= 1'b1;
		est <= 3'h5;
		bmv <= 1'b1;
		tw <= 32'hcafe_0123;
		rw <= 32'h8765_f00d;
		{tk, rk, se, bc} <= 16'h9c3a;
		@(posedge clk);
		bmv <= 1'b0;
		repeat (3) @(posedge clk);
		rdc(`TDP_REG_STATUS, 32'h0000_053e);
		rdc(`TDP_REG_STATUS, 32'h0000_051e);
		chk(i_tdp_if.tx_raw_word_copy, 32'hcafe_0123);
		chk(i_tdp_if.rx_raw_word_copy, 32'h8765_f00d);
		chk({16'h0, i_tdp_if.tx_kchar_flags_copy, i_tdp_if.rx_kchar_flags_copy,
			i_tdp_if.rx_running_sign_error_copy, i_tdp_if.rx_bad_code_copy}, 32'h9c3a);
		// Low byte only: loopback, eye reset and elastic reset pulses
		wr(`TDP_REG_CTRL, 32'h0);
		wb(1'b1, `TDP_REG_CTRL, 32'h1f1f_0fa2, 4'h1, q);
		wr(4'h6, 32'hffff_ffff);
		rdc(4'h6, 32'h0);
		chk({12'h0, outs}, 32'h0004_0000);
		chk({8'(ner), 8'(nel), 16'(nacc)}, 32'h0101_0003);
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		rdc(`TDP_REG_CTRL, 32'h0);
		rdc(`TDP_REG_CFG_RESULT, 32'h0);
		chk({12'h0, outs}, 32'h0);
		test_done();
	end
endmodule
